// ### design/sq_pkg.sv
// Constants and carriers for the serial queue sequencer.
// Assumes a 32-bit AXI4-Lite master and an external shift engine.
package sq_pkg;

	localparam logic [11:0] ADDR_DLY = 12'h344;
	localparam logic [11:0] ADDR_WRAP = 12'h348;
	localparam logic [11:0] ADDR_STAT = 12'h34c;
	localparam logic [11:0] ADDR_MASK = 12'h358;

	localparam logic [15:0] DLY_RESET = 16'h0404;
	localparam logic [15:0] WRAP_RESET = 16'h0000;
	localparam logic LOCK_RESET = 1'h0;

	localparam int RUN_BIT = 15;
	localparam int LOCK_BIT = 12;
	localparam int ABORT_BIT = 2;
	localparam int FIN_BIT = 0;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic run;
		logic [6:0] csd;
		logic [7:0] ptd;
	} dly_t;

	typedef struct packed {
		logic halt;
		logic wrap_on;
		logic wrap_tgt;
		logic idle_lvl;
		logic [3:0] end_ptr;
		logic [3:0] done_ptr;
		logic [3:0] start_ptr;
	} wrap_t;

	typedef struct packed {
		logic use_ptd;
		logic use_csd;
		logic [3:0] sel;
	} cmd_entry_t;

	typedef enum logic [2:0] {SEL_DLY, SEL_WRAP, SEL_STAT, SEL_MASK, SEL_NONE} sel_t;
	typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_SHIFT, ST_TRAIL} st_t;

endpackage : sq_pkg

// ### design/serial_queue_sequencer_control.sv
// Queue sequencer with enable, delays, pointers and AXI4-Lite registers.
// Assumes command RAM answers o_cmd_index combinationally and the shift
// engine toggles i_xfer_done_tgl on its own clock when a transfer ends.
// Operation
// [RULE1] Enable starts queue at start pointer
// [RULE2] Completion clears enable by itself
// [RULE3] Software clear aborts unless lockout set
// [RULE4] Software should stop queue by halt
// [RULE5] Clock-start delay after selects when flagged
// [RULE6] Post-transfer delay after transfer when flagged
// [RULE7] Halt finishes current command then stops
// [RULE8] No wrap: stop after end entry
// [RULE9] Wrap: continue after end entry
// [RULE10] Wrap target picks zero or start
// [RULE11] Idle selects follow idle level bit
// [RULE12] End pointer marks final entry
// [RULE13] Completed pointer is read-only progress
// [RULE14] Start pointer selects first entry
// [RULE15] Lockout: only completion clears enable
// [RULE16] Software clear sets abort flag, W1C
// [RULE17] Finished flag on end or halt
// [RULE18] Completed pointer updates before next entry
`timescale 1ns/1ns
`default_nettype none
module serial_queue_sequencer_control
	import sq_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rstn,
	input wire logic i_clk_en,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [11:0] i_awaddr,
	input wire logic i_wvalid,
	output logic o_wready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	output logic o_bvalid,
	input wire logic i_bready,
	output logic [1:0] o_bresp,
	input wire logic i_arvalid,
	output logic o_arready,
	input wire logic [11:0] i_araddr,
	output logic o_rvalid,
	input wire logic i_rready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	input wire cmd_entry_t i_cmd_entry,
	input wire logic i_xfer_done_tgl,
	output logic [3:0] o_cmd_index,
	output logic o_xfer_start,
	output logic [3:0] o_chip_sel,
	output logic o_irq
);

	function automatic sel_t decode(input logic [11:0] a);
		if (a == ADDR_DLY) begin
			decode = SEL_DLY;
		end else if (a == ADDR_WRAP) begin
			decode = SEL_WRAP;
		end else if (a == ADDR_STAT) begin
			decode = SEL_STAT;
		end else if (a == ADDR_MASK) begin
			decode = SEL_MASK;
		end else begin
			decode = SEL_NONE;
		end
	endfunction : decode

	function automatic logic [15:0] merge(input logic [15:0] o, input logic [31:0] d,
		input logic [3:0] s);
		merge = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
	endfunction : merge

	dly_t dly_reg, dly_next;
	wrap_t wrap_reg, wrap_next;
	st_t st_reg, st_next;
	logic lock_reg, lock_next;
	logic fin_reg, fin_next;
	logic abort_reg, abort_next;
	logic fin_mask_reg, fin_mask_next;
	logic abort_mask_reg, abort_mask_next;
	logic [3:0] ptr_reg, ptr_next;
	logic [7:0] cnt_reg, cnt_next;
	logic start_reg, start_next;
	logic [3:0] cs_reg, cs_next;
	logic sync1_reg, sync2_reg, sync3_reg;
	logic aw_got_reg, aw_got_next;
	logic w_got_reg, w_got_next;
	logic [11:0] awaddr_reg, awaddr_next;
	logic [31:0] wdata_reg, wdata_next;
	logic [3:0] wstrb_reg, wstrb_next;
	logic bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	logic rvalid_reg, rvalid_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0] rresp_reg, rresp_next;
	logic done_edge, do_wr, complete, last, stop, sw_clear;
	logic fin_set, abort_set;
	sel_t wr_sel, rd_sel;
	logic [15:0] nv, rv;

	// Edge of the engine's toggle; first stage feeds only the second
	assign done_edge = sync2_reg ^ sync3_reg;
	assign do_wr = aw_got_reg && w_got_reg && !bvalid_reg;
	assign o_awready = !aw_got_reg && !bvalid_reg;
	assign o_wready = !w_got_reg && !bvalid_reg;
	assign o_arready = !rvalid_reg;
	assign o_bvalid = bvalid_reg;
	assign o_bresp = bresp_reg;
	assign o_rvalid = rvalid_reg;
	assign o_rdata = rdata_reg;
	assign o_rresp = rresp_reg;
	assign o_cmd_index = ptr_reg;
	assign o_xfer_start = start_reg;
	assign o_chip_sel = cs_reg;
	assign o_irq = (fin_reg && fin_mask_reg) || (abort_reg && abort_mask_reg);

	always_comb begin
		dly_next = dly_reg;
		wrap_next = wrap_reg;
		st_next = st_reg;
		lock_next = lock_reg;
		fin_mask_next = fin_mask_reg;
		abort_mask_next = abort_mask_reg;
		ptr_next = ptr_reg;
		cnt_next = cnt_reg;
		start_next = 1'b0;
		complete = 1'b0;
		stop = 1'b0;
		sw_clear = 1'b0;
		fin_set = 1'b0;
		abort_set = 1'b0;
		// [RULE12] End entry match
		last = (ptr_reg == wrap_reg.end_ptr);
		case (st_reg)
			ST_IDLE: begin
				// [RULE1] [RULE14] Launch at start pointer
				if (dly_reg.run) begin
					st_next = ST_LEAD;
					ptr_next = wrap_reg.start_ptr;
					cnt_next = 8'h00;
				end
			end
			ST_LEAD: begin
				// [RULE5] Hold off first clock edge
				if (!i_cmd_entry.use_csd || cnt_reg >= {1'b0, dly_reg.csd}) begin
					start_next = 1'b1;
					st_next = ST_SHIFT;
					cnt_next = 8'h00;
				end else begin
					cnt_next = cnt_reg + 8'h01;
				end
			end
			ST_SHIFT: begin
				if (done_edge) begin
					if (i_cmd_entry.use_ptd) begin
						st_next = ST_TRAIL;
					end else begin
						complete = 1'b1;
					end
				end
			end
			ST_TRAIL: begin
				// [RULE6] Gap after the transfer
				if (cnt_reg >= dly_reg.ptd) begin
					complete = 1'b1;
				end else begin
					cnt_next = cnt_reg + 8'h01;
				end
			end
			default: begin
				st_next = ST_IDLE;
			end
		endcase
		if (complete) begin
			// [RULE13] [RULE18] Progress pointer before next entry
			wrap_next.done_ptr = ptr_reg;
			// [RULE17] Finished on end entry
			fin_set = last;
			if (wrap_reg.halt) begin
				// [RULE7] Halt after current command
				fin_set = 1'b1;
				stop = 1'b1;
			end else if (last && !wrap_reg.wrap_on) begin
				// [RULE8] Queue ends here
				stop = 1'b1;
			end else begin
				// [RULE9] [RULE10] Next entry or wrap point
				st_next = ST_LEAD;
				cnt_next = 8'h00;
				if (last) begin
					ptr_next = wrap_reg.wrap_tgt ? wrap_reg.start_ptr : 4'h0;
				end else begin
					ptr_next = ptr_reg + 4'h1;
				end
			end
			if (stop) begin
				// [RULE2] Self-clear of enable
				st_next = ST_IDLE;
				dly_next.run = 1'b0;
			end
		end
		wr_sel = decode(awaddr_reg);
		nv = 16'h0000;
		if (do_wr) begin
			if (wr_sel == SEL_DLY) begin
				nv = merge(dly_reg, wdata_reg, wstrb_reg);
				dly_next.csd = nv[14:8];
				dly_next.ptd = nv[7:0];
				if (nv[RUN_BIT]) begin
					dly_next.run = 1'b1;
				end else if (dly_next.run && !lock_reg) begin
					// [RULE3] [RULE16] Software abort
					sw_clear = 1'b1;
					dly_next.run = 1'b0;
					st_next = ST_IDLE;
					abort_set = 1'b1;
				end
				// [RULE15] Lockout keeps enable set
			end else if (wr_sel == SEL_WRAP) begin
				// Completed pointer is not writable
				nv = merge(wrap_reg, wdata_reg, wstrb_reg);
				wrap_next = wrap_t'({nv[15:8], wrap_next.done_ptr, nv[3:0]});
			end else if (wr_sel == SEL_STAT) begin
				if (wstrb_reg[1]) begin
					lock_next = wdata_reg[LOCK_BIT];
				end
			end else if (wr_sel == SEL_MASK) begin
				if (wstrb_reg[0]) begin
					fin_mask_next = wdata_reg[FIN_BIT];
					abort_mask_next = wdata_reg[ABORT_BIT];
				end
			end
		end
		// Set wins over a same-cycle write-one clear
		fin_next = fin_set || (fin_reg &&
			!(do_wr && wr_sel == SEL_STAT && wstrb_reg[0] && wdata_reg[FIN_BIT]));
		abort_next = abort_set || (abort_reg &&
			!(do_wr && wr_sel == SEL_STAT && wstrb_reg[0] && wdata_reg[ABORT_BIT]));
		// [RULE11] Idle select level
		cs_next = (st_reg != ST_IDLE) ? i_cmd_entry.sel : {4{wrap_reg.idle_lvl}};
	end

	always_comb begin
		aw_got_next = aw_got_reg;
		w_got_next = w_got_reg;
		awaddr_next = awaddr_reg;
		wdata_next = wdata_reg;
		wstrb_next = wstrb_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		rd_sel = decode(i_araddr);
		rv = 16'h0000;
		if (i_awvalid && o_awready) begin
			aw_got_next = 1'b1;
			awaddr_next = i_awaddr;
		end
		if (i_wvalid && o_wready) begin
			w_got_next = 1'b1;
			wdata_next = i_wdata;
			wstrb_next = i_wstrb;
		end
		if (do_wr) begin
			aw_got_next = 1'b0;
			w_got_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
		end else if (bvalid_reg && i_bready) begin
			bvalid_next = 1'b0;
		end
		if (rd_sel == SEL_DLY) begin
			rv = dly_reg;
		end else if (rd_sel == SEL_WRAP) begin
			rv = wrap_reg;
		end else if (rd_sel == SEL_STAT) begin
			rv[LOCK_BIT] = lock_reg;
			rv[ABORT_BIT] = abort_reg;
			rv[FIN_BIT] = fin_reg;
		end else if (rd_sel == SEL_MASK) begin
			rv[ABORT_BIT] = abort_mask_reg;
			rv[FIN_BIT] = fin_mask_reg;
		end
		if (i_arvalid && o_arready) begin
			rvalid_next = 1'b1;
			rdata_next = {16'h0000, rv};
			rresp_next = (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
		end else if (rvalid_reg && i_rready) begin
			rvalid_next = 1'b0;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			dly_reg <= dly_t'(DLY_RESET);
			wrap_reg <= wrap_t'(WRAP_RESET);
			st_reg <= ST_IDLE;
			lock_reg <= LOCK_RESET;
			fin_reg <= 1'b0;
			abort_reg <= 1'b0;
			fin_mask_reg <= 1'b0;
			abort_mask_reg <= 1'b0;
			ptr_reg <= 4'h0;
			cnt_reg <= 8'h00;
			start_reg <= 1'b0;
			cs_reg <= 4'h0;
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			sync3_reg <= 1'b0;
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			awaddr_reg <= 12'h000;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= RESP_OKAY;
		end else if (i_clk_en) begin
			dly_reg <= dly_next;
			wrap_reg <= wrap_next;
			st_reg <= st_next;
			lock_reg <= lock_next;
			fin_reg <= fin_next;
			abort_reg <= abort_next;
			fin_mask_reg <= fin_mask_next;
			abort_mask_reg <= abort_mask_next;
			ptr_reg <= ptr_next;
			cnt_reg <= cnt_next;
			start_reg <= start_next;
			cs_reg <= cs_next;
			sync1_reg <= i_xfer_done_tgl;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			aw_got_reg <= aw_got_next;
			w_got_reg <= w_got_next;
			awaddr_reg <= awaddr_next;
			wdata_reg <= wdata_next;
			wstrb_reg <= wstrb_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
		end
	end

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rstn || !i_clk_en);

	sequence seq_launch;
		st_reg == ST_IDLE && dly_reg.run && !sw_clear;
	endsequence
	sequence seq_end_done;
		complete && last && !wrap_reg.halt;
	endsequence

	chk_start_ptr: assert property (seq_launch |=> st_reg == ST_LEAD && // [RULE1]
		ptr_reg == $past(wrap_reg.start_ptr)) else $error("queue did not start at start ptr");
	chk_auto_clear: assert property (seq_end_done ##0 !wrap_reg.wrap_on |=> // [RULE8]
		!dly_reg.run && st_reg == ST_IDLE && fin_reg) else $error("queue end did not stop");
	chk_abort_flag: assert property (sw_clear |=> !dly_reg.run && abort_reg && // [RULE16]
		st_reg == ST_IDLE) else $error("abort not taken");
	chk_lockout_hold: assert property (do_wr && wr_sel == SEL_DLY && lock_reg && // [RULE15]
		dly_reg.run && !complete |=> dly_reg.run) else $error("lockout let enable clear");
	chk_lead_delay: assert property (st_reg == ST_LEAD && i_cmd_entry.use_csd && // [RULE5]
		cnt_reg < {1'b0, dly_reg.csd} && !sw_clear |=> st_reg == ST_LEAD && !start_reg)
		else $error("clock-start delay cut short");
	chk_trail_delay: assert property (st_reg == ST_TRAIL && cnt_reg < dly_reg.ptd && // [RULE6]
		!sw_clear |=> st_reg == ST_TRAIL) else $error("post-transfer delay cut short");
	chk_halt_stop: assert property (complete && wrap_reg.halt && !sw_clear |=> // [RULE7]
		st_reg == ST_IDLE && fin_reg ##1 st_reg == ST_IDLE) else $error("halt did not stop");
	chk_wrap_target: assert property (seq_end_done ##0 wrap_reg.wrap_on && !sw_clear |=> // [RULE10]
		ptr_reg == ($past(wrap_reg.wrap_tgt) ? $past(wrap_reg.start_ptr) : 4'h0))
		else $error("wrap went to wrong entry");
	chk_idle_level: assert property (st_reg == ST_IDLE ##1 st_reg == ST_IDLE |-> // [RULE11]
		o_chip_sel == {4{$past(wrap_reg.idle_lvl)}}) else $error("idle select level wrong");
	chk_done_ptr: assert property (complete |=> wrap_reg.done_ptr == $past(ptr_reg)) // [RULE13]
		else $error("completed pointer not updated");

endmodule : serial_queue_sequencer_control
`default_nettype wire

// ### verif/sq_engine_model.sv
// Partner model: command memory and shift engine on the link clock.
// Assumes one done toggle is owed for every start pulse.
`timescale 1ns/1ns
`default_nettype none
module sq_engine_model
	import sq_pkg::*;
#(
	parameter int LAT = 3
)
(
	input wire logic i_core_clk,
	input wire logic i_link_clk,
	input wire logic i_slow,
	input wire logic [3:0] i_index,
	input wire logic i_start,
	output var cmd_entry_t o_entry,
	output logic o_done_tgl
);
	int req = 0;
	int ack = 0;
	int cnt = 0;
	// Flags from index bits so every flag mix occurs
	assign o_entry = {i_index[1], i_index[0], ~i_index};
	always @(posedge i_core_clk) begin
		if (i_start)
			req <= req + 1;
	end
	// Fast or slow answer, never twice per start
	always @(posedge i_link_clk) begin
		if (ack != req) begin
			if (cnt >= (i_slow ? LAT : 0)) begin
				o_done_tgl <= ~o_done_tgl;
				ack <= ack + 1;
				cnt <= 0;
			end else begin
				cnt <= cnt + 1;
			end
		end
	end
	initial o_done_tgl = 1'b0;
endmodule : sq_engine_model
`default_nettype wire

// ### verif/serial_queue_sequencer_control_tb_top.sv
// Bench: AXI4-Lite master, queue runs, flags and interrupt.
// Assumes the engine model answers each start with one toggle.
`timescale 1ns/1ns
`default_nettype none
module serial_queue_sequencer_control_tb_top import sq_pkg::*; ;
	logic clk = 0, lclk = 0, rstn = 0, awv = 0, wv = 0, bry = 0;
	logic arv = 0, rry = 0, slow = 0, lock = 0, first = 0, tq = 0;
	logic [11:0] awa = 0, ara = 0;
	logic [31:0] wd = 0, rdd;
	logic awr, wrr, bv, arr, rv, irq, xs, tgl;
	logic [1:0] br, rr;
	logic [3:0] idx, cs, prev = 0;
	cmd_entry_t ent;
	logic [6:0] csd_r = 0;
	logic [7:0] ptd_r = 0;
	logic [33:0] exp_q[$];
	logic [7:0] idx_q[$];
	int failures = 0, checks_done = 0, starts = 0, gap = 0;
	initial forever #20 clk = ~clk;
	initial begin
		#7;
		forever #160 lclk = ~lclk;
	end
	serial_queue_sequencer_control serial_queue_sequencer_control_inst (
		.i_core_clk(clk), .i_rstn(rstn), .i_clk_en(1'b1),
		.i_awvalid(awv), .o_awready(awr), .i_awaddr(awa),
		.i_wvalid(wv), .o_wready(wrr), .i_wdata(wd), .i_wstrb(4'hf),
		.o_bvalid(bv), .i_bready(bry), .o_bresp(br),
		.i_arvalid(arv), .o_arready(arr), .i_araddr(ara),
		.o_rvalid(rv), .i_rready(rry), .o_rdata(rdd), .o_rresp(rr),
		.i_cmd_entry(ent), .i_xfer_done_tgl(tgl), .o_cmd_index(idx),
		.o_xfer_start(xs), .o_chip_sel(cs), .o_irq(irq));
	sq_engine_model #(.LAT(3)) sq_engine_model_inst (
		.i_core_clk(clk), .i_link_clk(lclk), .i_slow(slow),
		.i_index(idx), .i_start(xs), .o_entry(ent), .o_done_tgl(tgl));
	task automatic cmp_val(input logic [33:0] got, input logic [33:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_val
	task automatic complete_run;
		if (failures == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : complete_run
	// Sampled at the falling edge, where outputs are settled
	always @(negedge clk) begin : mon
		int n;
		gap++;
		if (tgl !== tq) begin
			tq = tgl;
			gap = 0;
		end
		if (bv && bry)
			cmp_val({br, 32'h0}, exp_q.pop_front());
		if (rv && rry)
			cmp_val({rr, rdd}, exp_q.pop_front());
		if (xs) begin
			n = 4 + (prev[1] ? ptd_r + 1 : 0) + (idx[0] ? csd_r : 0);
			cmp_val({26'h0, idx, cs}, {26'h0, idx_q.pop_front()});
			if (!first)
				cmp_val({33'h0, gap >= n - 1 && gap <= n + 1}, 34'h1);
			first = 0;
			prev = idx;
			starts++;
		end
	end
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
		logic ta, tw, tb;
		exp_q.push_back({r, 32'h0});
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		tb = 0;
		// No cycle limit; a hang is left to the watchdog
		while (!tb) begin
			@(negedge clk);
			ta = awv && awr;
			tw = wv && wrr;
			tb = bv;
			@(posedge clk);
			if (ta)
				awv <= 1'b0;
			if (tw)
				wv <= 1'b0;
		end
		bry <= 1'b0;
		@(posedge clk);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [33:0] e);
		logic ta, tr;
		exp_q.push_back(e);
		ara <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		tr = 0;
		while (!tr) begin
			@(negedge clk);
			ta = arv && arr;
			tr = rv;
			@(posedge clk);
			if (ta)
				arv <= 1'b0;
		end
		rry <= 1'b0;
		@(posedge clk);
	endtask : rd
	// Negative count waits for the interrupt instead of starts
	task automatic wait_for(input int k);
		int n;
		n = 0;
		while ((k < 0 ? irq !== 1'b1 : starts < k) && n < 5000) begin
			@(negedge clk);
			n++;
		end
		if (n >= 5000)
			failures++;
		@(posedge clk);
	endtask : wait_for
	task automatic pin_chk(input logic lvl, input logic v);
		@(negedge clk);
		cmp_val({29'h0, cs, irq}, {29'h0, {4{lvl}}, v});
		@(posedge clk);
	endtask : pin_chk
	task automatic go(input logic [3:0] s, e, input logic won, tgt, lvl, input int cnt, k, act);
		logic [3:0] p, last;
		logic [6:0] c;
		logic [7:0] d;
		logic [15:0] w;
		logic ab;
		c = 7'($urandom % 32);
		d = 8'($urandom % 64);
		w = {1'b0, won, tgt, lvl, e, 4'h0, s};
		ab = act == 2 && !lock;
		slow <= act != 0 || $urandom % 2;
		csd_r = c;
		ptd_r = d;
		wr(ADDR_STAT, {19'h0, lock, 12'h5}, RESP_OKAY);
		wr(ADDR_WRAP, {16'h0, w}, RESP_OKAY);
		pin_chk(lvl, 1'b0);
		p = s;
		for (int i = 0; i < cnt; i++) begin
			idx_q.push_back({p, ~p});
			last = p;
			p = p == e ? (tgt ? s : 4'h0) : p + 4'h1;
		end
		first = 1;
		starts = 0;
		wr(ADDR_DLY, {16'h0, 1'b1, c, d}, RESP_OKAY);
		if (act == 1) begin
			wait_for(k);
			wr(ADDR_WRAP, {16'h0, w | 16'h8000}, RESP_OKAY);
			// End-of-pass flag already up in wrap mode; clear it before the halt wait
			rd(ADDR_STAT, {RESP_OKAY, 16'h0, 3'h0, lock, 12'h1});
			wr(ADDR_STAT, {19'h0, lock, 12'h1}, RESP_OKAY);
		end else if (act == 2) begin
			wait_for(k);
			wr(ADDR_DLY, {16'h0, 1'b0, c, d}, RESP_OKAY);
			rd(ADDR_DLY, {RESP_OKAY, 16'h0, lock, c, d});
		end
		wait_for(-1);
		rd(ADDR_DLY, {RESP_OKAY, 16'h0, 1'b0, c, d});
		if (!ab)
			rd(ADDR_WRAP, {RESP_OKAY, 16'h0, act == 1, won, tgt, lvl, e, last, s});
		rd(ADDR_STAT, {RESP_OKAY, 16'h0, 3'h0, lock, 9'h0, ab, 1'b0, !ab});
		wr(ADDR_MASK, 32'h0, RESP_OKAY);
		pin_chk(lvl, 1'b0);
		wr(ADDR_MASK, 32'h5, RESP_OKAY);
		pin_chk(lvl, 1'b1);
	endtask : go
	initial begin
		void'($urandom(32'h55730223));
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		rd(ADDR_DLY, {RESP_OKAY, 16'h0, DLY_RESET});
		rd(ADDR_WRAP, {RESP_OKAY, 16'h0, WRAP_RESET});
		rd(12'h3f0, {RESP_SLVERR, 32'h0});
		wr(12'h3f0, 32'hffff, RESP_SLVERR);
		wr(ADDR_MASK, 32'h5, RESP_OKAY);
		go(4'h2, 4'h4, 0, 0, 1, 3, 0, 0);
		go(4'he, 4'hf, 1, 0, 0, 3, 3, 1);
		go(4'he, 4'hf, 1, 1, 1, 3, 3, 1);
		lock = 1;
		go(4'h0, 4'h1, 0, 0, 0, 2, 1, 2);
		lock = 0;
		go(4'h3, 4'h9, 0, 0, 1, 1, 1, 2);
		complete_run();
	end
	// Cuts a hang well past the expected run length
	initial begin
		#3000000;
		failures++;
		complete_run();
	end
endmodule : serial_queue_sequencer_control_tb_top
`default_nettype wire
